// ### src/ppt_pkg.sv
package ppt_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_PEN = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_WDATA = 8'h14;
  localparam logic [7:0] OFF_RDATA = 8'h18;
  localparam logic [7:0] OFF_IBUF = 8'h20;
  localparam logic [7:0] OFF_OUTPUT_UNDERFLOW_FLAG = 8'h30;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MODE_BUSY = 15;
  localparam int MODE_ADDRESS_STEP_SELECT = 11;
  localparam int MODE_SEL = 8;
  localparam int MODE_SETUP_WAIT_COUNT = 6;
  localparam int MODE_STROBE_WAIT_COUNT = 2;
  localparam int MODE_HOLD_WAIT_COUNT = 0;
  localparam int ADDR_CS = 14;
  localparam int CTRL_ON = 15;
  localparam int CTRL_MUX = 11;
  localparam int CTRL_CSF = 6;
  localparam int CTRL_ALP = 5;
  localparam int CTRL_CSP = 3;
  localparam int CTRL_WRSP = 1;
  localparam int CTRL_RDSP = 0;
  localparam int ST_IBF = 15;
  localparam int ST_INPUT_OVERFLOW_FLAG = 14;
  localparam int ST_INPUT_BUFFER_FULL_BITS = 8;
  localparam int ST_OBE = 7;
  localparam int ST_OUTPUT_UNDERFLOW_FLAG = 6;
  localparam int ST_OUTPUT_BUFFER_EMPTY_BITS = 0;
  // ----------------------------------------
  // Masks and reset values
  // ----------------------------------------
  localparam logic [31:0] MODE_WMASK = 32'h0000_7bff;
  localparam logic [31:0] ADDR_WMASK = 32'h0000_47ff;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_98eb;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
  localparam logic [3:0] OBE_RST = 4'hf;
  localparam logic [3:0] IBF_RST = 4'h0;
  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] MD_LEGACY = 2'b00;
  localparam logic [1:0] MD_ENH = 2'b01;
  localparam logic [1:0] MD_SEP = 2'b10;
  localparam logic [1:0] MD_COMB = 2'b11;
  localparam logic [1:0] INC_UP = 2'b01;
  localparam logic [1:0] INC_DN = 2'b10;
  localparam logic [1:0] INC_BUF = 2'b11;
  localparam logic [1:0] CSF_CS = 2'b10;
  localparam logic [1:0] MUX_NONE = 2'b00;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_STROBE = 4'b0100,
    ST_HOLD = 4'b1000
  } ppt_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] data;
  } ppt_pins_t;
endpackage : ppt_pkg

// ### src/ppt_port_cfg.sv
module ppt_port_cfg (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ppt_pkg::ppt_pins_t pinIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  output logic rdStrobe,
  output logic wrStrobe,
  output logic [14:0] addrOut,
  output logic [14:0] addrOe,
  output logic busy
);
  import ppt_pkg::*;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [3:0] setupLen(input logic [31:0] m);
    setupLen = (m[MODE_STROBE_WAIT_COUNT+:4] == 4'h0) ? 4'h1 : {2'b00, m[MODE_SETUP_WAIT_COUNT+:2]} + 4'h1;
  endfunction : setupLen

  function automatic logic [3:0] holdLen(input logic [31:0] m, input logic wr);
    if (m[MODE_STROBE_WAIT_COUNT+:4] == 4'h0) begin
      holdLen = wr ? 4'h1 : 4'h0;
    end else if (wr) begin
      holdLen = {2'b00, m[MODE_HOLD_WAIT_COUNT+:2]} + 4'h1;
    end else begin
      holdLen = {2'b00, m[MODE_HOLD_WAIT_COUNT+:2]};
    end
  endfunction : holdLen

  function automatic logic [14:0] stepAddr(input logic [14:0] a, input logic [1:0] inc,
                                           input logic csOn);
    logic [9:0] s;
    s = {a[14], a[10:2]};
    if (csOn) begin
      s[9] = 1'b0;
    end
    if (inc == INC_UP) begin
      s = s + 10'h001;
    end else if (inc == INC_DN) begin
      s = s - 10'h001;
    end
    stepAddr = {csOn ? a[14] : s[9], a[13:11], s[8:0], a[1:0]};
  endfunction : stepAddr

  // ----------------------------------------
  // Registers and decode
  // ----------------------------------------
  logic [31:0] mode_r;
  logic [31:0] ctrl_r;
  logic [14:0] addr_r;
  logic [14:0] pen_r;
  logic [3:0] ibFull_r;
  logic [3:0] obEmpty_r;
  logic input_overflow_flag_r;
  logic output_underflow_flag_r;
  logic [7:0] inBuf_r [4];
  logic [7:0] outBuf_r [4];
  logic [1:0] inPtr_r;
  logic [1:0] outPtr_r;
  logic [7:0] wrData_r;
  logic [7:0] rdData_r;
  ppt_state_t state_r;
  logic [3:0] cnt_r;
  logic isWr_r;
  ppt_pins_t sync1_r;
  ppt_pins_t sync2_r;
  logic wrPrev_r;
  logic rdPrev_r;

  logic acc;
  logic wrAcc;
  logic rdAcc;
  logic [1:0] mdSel;
  logic isOn;
  logic isMaster;
  logic isSlave;
  logic csOn;
  logic hostWr;
  logic hostRd;
  logic [1:0] inIdx;
  logic [1:0] outIdx;
  logic startWr;
  logic startRd;
  logic phaseEnd;
  logic xferDone;
  logic [3:0] swRdClr;
  logic [3:0] swWrSet;
  logic mapped;
  logic [31:0] rdMux;
  logic [31:0] statVal;

  assign acc = psel && penable;
  assign wrAcc = acc && pwrite;
  assign rdAcc = acc && !pwrite;
  assign mdSel = mode_r[MODE_SEL+:2];
  assign isOn = ctrl_r[CTRL_ON];
  assign isMaster = isOn && mdSel[1];
  assign isSlave = isOn && !mdSel[1];
  assign csOn = ctrl_r[CTRL_CSF+:2] == CSF_CS;
  assign pready = 1'b1;

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      wrPrev_r <= 1'b0;
      rdPrev_r <= 1'b0;
    end else begin
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
      wrPrev_r <= sync2_r.wr;
      rdPrev_r <= sync2_r.rd;
    end
  end

  assign hostWr = isSlave && sync2_r.wr && !wrPrev_r;
  assign hostRd = isSlave && sync2_r.rd && !rdPrev_r;
  // Legacy slave has no address pins, so a pointer picks the buffer
  assign inIdx = (mdSel == MD_ENH) ? sync2_r.addr : inPtr_r;
  assign outIdx = (mdSel == MD_ENH) ? sync2_r.addr : outPtr_r;

  // ----------------------------------------
  // APB read side
  // ----------------------------------------
  assign statVal = {16'h0000, &ibFull_r, input_overflow_flag_r, 2'b00, ibFull_r,
                    &obEmpty_r, output_underflow_flag_r, 2'b00, obEmpty_r};

  always_comb begin
    mapped = 1'b1;
    rdMux = 32'h0000_0000;
    unique case (paddr)
      OFF_MODE: rdMux = {16'h0000, state_r != ST_IDLE, mode_r[14:0]};
      OFF_ADDR: rdMux = {17'h00000, addr_r};
      OFF_PEN: rdMux = {17'h00000, pen_r};
      OFF_STAT: rdMux = statVal;
      OFF_CTRL: rdMux = ctrl_r;
      OFF_WDATA: rdMux = {24'h000000, wrData_r};
      OFF_RDATA: rdMux = {24'h000000, rdData_r};
      default: begin
        if (paddr[7:4] == OFF_IBUF[7:4] && paddr[1:0] == 2'b00) begin
          rdMux = {24'h000000, inBuf_r[paddr[3:2]]};
        end else if (paddr[7:4] == OFF_OUTPUT_UNDERFLOW_FLAG[7:4] && paddr[1:0] == 2'b00) begin
          rdMux = {24'h000000, outBuf_r[paddr[3:2]]};
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  assign prdata = (psel && !pwrite && mapped) ? rdMux : 32'h0000_0000;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= ZERO_RST;
      ctrl_r <= ZERO_RST;
      pen_r <= ZERO_RST[14:0];
    end else if (wrAcc) begin
      if (paddr == OFF_MODE) begin
        mode_r <= pwdata & MODE_WMASK;
      end
      if (paddr == OFF_CTRL) begin
        ctrl_r <= pwdata & CTRL_WMASK;
      end
      if (paddr == OFF_PEN) begin
        pen_r <= pwdata[14:0] & ADDR_WMASK[14:0];
      end
    end
  end

  // Software write wins over the step of the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= ZERO_RST[14:0];
    end else if (wrAcc && paddr == OFF_ADDR) begin
      addr_r <= pwdata[14:0] & ADDR_WMASK[14:0];
    end else if (xferDone) begin
      addr_r <= stepAddr(addr_r, mode_r[MODE_ADDRESS_STEP_SELECT+:2], csOn);
    end
  end

  // ----------------------------------------
  // Master transfer sequencer
  // ----------------------------------------
  assign startWr = wrAcc && paddr == OFF_WDATA && isMaster && state_r == ST_IDLE;
  assign startRd = wrAcc && paddr == OFF_RDATA && isMaster && state_r == ST_IDLE;
  assign phaseEnd = cnt_r == 4'h0;
  assign xferDone = (state_r == ST_HOLD && phaseEnd)
                    || (state_r == ST_STROBE && phaseEnd && holdLen(mode_r, isWr_r) == 4'h0);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      isWr_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (startWr || startRd) begin
            state_r <= ST_SETUP;
            cnt_r <= setupLen(mode_r) - 4'h1;
            isWr_r <= startWr;
          end
        end
        ST_SETUP: begin
          if (phaseEnd) begin
            state_r <= ST_STROBE;
            cnt_r <= mode_r[MODE_STROBE_WAIT_COUNT+:4];
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ST_STROBE: begin
          if (phaseEnd && holdLen(mode_r, isWr_r) == 4'h0) begin
            state_r <= ST_IDLE;
          end else if (phaseEnd) begin
            state_r <= ST_HOLD;
            cnt_r <= holdLen(mode_r, isWr_r) - 4'h1;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ST_HOLD: begin
          if (phaseEnd) begin
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrData_r <= 8'h00;
      rdData_r <= 8'h00;
    end else begin
      if (startWr) begin
        wrData_r <= pwdata[7:0];
      end
      // Byte is taken on the last strobe cycle, once past the synchroniser
      if (state_r == ST_STROBE && phaseEnd && !isWr_r) begin
        rdData_r <= sync2_r.data;
      end
    end
  end

  assign busy = state_r != ST_IDLE;

  // ----------------------------------------
  // Slave buffers
  // ----------------------------------------
  always_comb begin
    swRdClr = 4'h0;
    swWrSet = 4'h0;
    if (rdAcc && paddr[7:4] == OFF_IBUF[7:4] && paddr[1:0] == 2'b00) begin
      swRdClr[paddr[3:2]] = 1'b1;
    end
    if (wrAcc && paddr[7:4] == OFF_OUTPUT_UNDERFLOW_FLAG[7:4] && paddr[1:0] == 2'b00) begin
      swWrSet[paddr[3:2]] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ibFull_r <= IBF_RST;
      obEmpty_r <= OBE_RST;
      for (int i = 0; i < 4; i++) begin
        inBuf_r[i] <= 8'h00;
        outBuf_r[i] <= 8'h00;
      end
    end else begin
      // Host read's empty set wins over a software load in the same cycle; a host write to a full buffer overflows as software reads it
      ibFull_r <= (ibFull_r & ~swRdClr)
                  | ((hostWr && !ibFull_r[inIdx]) ? (4'h1 << inIdx) : 4'h0);
      obEmpty_r <= (obEmpty_r & ~swWrSet)
                   | ((hostRd && !obEmpty_r[outIdx]) ? (4'h1 << outIdx) : 4'h0);
      if (hostWr && !ibFull_r[inIdx]) begin
        inBuf_r[inIdx] <= sync2_r.data;
      end
      for (int i = 0; i < 4; i++) begin
        if (swWrSet[i]) begin
          outBuf_r[i] <= pwdata[7:0];
        end
      end
    end
  end

  // Error flags clear by writing zero; a new event in that cycle still sets
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      input_overflow_flag_r <= 1'b0;
      output_underflow_flag_r <= 1'b0;
    end else begin
      input_overflow_flag_r <= (hostWr && ibFull_r[inIdx])
                || (input_overflow_flag_r && !(wrAcc && paddr == OFF_STAT && !pwdata[ST_INPUT_OVERFLOW_FLAG]));
      output_underflow_flag_r <= (hostRd && obEmpty_r[outIdx])
                || (output_underflow_flag_r && !(wrAcc && paddr == OFF_STAT && !pwdata[ST_OUTPUT_UNDERFLOW_FLAG]));
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      inPtr_r <= 2'b00;
      outPtr_r <= 2'b00;
    end else if (mdSel == MD_LEGACY && mode_r[MODE_ADDRESS_STEP_SELECT+:2] == INC_BUF) begin
      if (hostWr) begin
        inPtr_r <= inPtr_r + 2'b01;
      end
      if (hostRd) begin
        outPtr_r <= outPtr_r + 2'b01;
      end
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  logic [7:0] dataNxt;
  logic oeNxt;
  always_comb begin
    dataNxt = dataOut;
    oeNxt = 1'b0;
    if (isMaster && state_r != ST_IDLE) begin
      // Multiplexed modes put the low address on the data lines in setup
      if (state_r == ST_SETUP && ctrl_r[CTRL_MUX+:2] != MUX_NONE) begin
        dataNxt = addr_r[7:0];
        oeNxt = 1'b1;
      end else begin
        dataNxt = wrData_r;
        oeNxt = isWr_r;
      end
    end else if (isSlave && sync2_r.rd) begin
      dataNxt = outBuf_r[outIdx];
      oeNxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataOut <= 8'h00;
      dataOe <= 1'b0;
    end else begin
      dataOut <= dataNxt;
      dataOe <= oeNxt;
    end
  end

  logic strobeAct;
  logic latchAct;
  assign strobeAct = state_r == ST_STROBE;
  assign latchAct = state_r == ST_SETUP && ctrl_r[CTRL_MUX+:2] != MUX_NONE;
  // Combined mode: read line carries direction, write line the enable
  assign rdStrobe = ~ctrl_r[CTRL_RDSP] ^ ((mdSel == MD_COMB) ? (busy && !isWr_r)
                                          : (strobeAct && !isWr_r)) ;
  assign wrStrobe = ~ctrl_r[CTRL_WRSP] ^ ((mdSel == MD_COMB) ? strobeAct
                                          : (strobeAct && isWr_r));

  always_comb begin
    addrOut = {1'b0, 3'b000, addr_r[10:0]};
    addrOut[14] = csOn ? (~ctrl_r[CTRL_CSP] ^ addr_r[ADDR_CS]) : addr_r[ADDR_CS];
    if (ctrl_r[CTRL_MUX+:2] != MUX_NONE) begin
      addrOut[1:0] = {2{~ctrl_r[CTRL_ALP] ^ latchAct}};
    end
    addrOe = 15'h0000;
    if (isMaster) begin
      addrOe[14] = pen_r[14];
      addrOe[10:2] = pen_r[10:2];
      addrOe[1:0] = pen_r[1:0];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  int unsigned strobeCnt;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobeCnt <= 0;
    end else begin
      strobeCnt <= strobeAct ? strobeCnt + 1 : 0;
    end
  end

  sequence enterStrobe;
    state_r == ST_SETUP ##1 state_r == ST_STROBE;
  endsequence

  a_strobe_len: assert property ($fell(strobeAct) |->
    strobeCnt == $past(mode_r[MODE_STROBE_WAIT_COUNT+:4]) + 1)
    else $error("strobe length wrong");
  a_write_hold: assert property (enterStrobe ##0 isWr_r && mode_r[MODE_STROBE_WAIT_COUNT+:4] == 4'h0
    && !wrAcc |-> ##1 strobeAct == 1'b0 ##0 state_r == ST_HOLD ##1 state_r == ST_IDLE)
    else $error("fast write hold wrong");
  a_read_nohold: assert property ($fell(strobeAct) && !isWr_r
    && $past(mode_r[MODE_HOLD_WAIT_COUNT+:2]) == 2'b00 |-> state_r == ST_IDLE)
    else $error("read hold not zero");
  a_hold_seq: assert property (state_r == ST_HOLD && phaseEnd |=> state_r == ST_IDLE)
    else $error("hold did not end");
  a_busy_flag: assert property ((startWr || startRd) |=> busy && state_r == ST_SETUP)
    else $error("busy mismatch");
  a_cs_fixed: assert property (xferDone && csOn && !wrAcc
    |=> addr_r[ADDR_CS] == $past(addr_r[ADDR_CS]))
    else $error("chip select stepped");
  a_ovf_set: assert property (hostWr && ibFull_r[inIdx] |=> input_overflow_flag_r)
    else $error("overflow not set");
  a_unf_set: assert property (hostRd && obEmpty_r[outIdx] |=> output_underflow_flag_r)
    else $error("underflow not set");
  a_full_clr: assert property (|swRdClr && !hostWr |=> (ibFull_r & $past(swRdClr)) == 4'h0)
    else $error("read did not clear full");
  a_empty_clr: assert property (|swWrSet && !hostRd |=> (obEmpty_r & $past(swWrSet)) == 4'h0)
    else $error("write did not clear empty");
endmodule : ppt_port_cfg

// ### tb/ppt_host_model.sv
module ppt_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  output ppt_pkg::ppt_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import ppt_pkg::*;
  logic wrR = 1'b0;
  logic rdR = 1'b0;
  logic drvOn = 1'b0;
  logic [1:0] addrR = 2'b00;
  logic [7:0] drvByte = 8'h00;
  logic [7:0] idleByte = 8'h00;
  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // Released data lines wander so a stale byte is never mistaken for data
  always @(posedge ref_clk) idleByte <= idleByte + 8'h35;
  always_comb pins = '{wr: wrR, rd: rdR, addr: addrR, data: drvOn ? drvByte : idleByte};
  // ----------------------------------------
  // Host and peripheral actions
  // ----------------------------------------
  task automatic host_write(input logic [1:0] b, input logic [7:0] d);
    @(posedge ref_clk);
    addrR <= b;
    drvByte <= d;
    drvOn <= 1'b1;
    @(posedge ref_clk);
    wrR <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wrR <= 1'b0;
    repeat (2) @(posedge ref_clk);
    drvOn <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : host_write
  task automatic host_read(input logic [1:0] b, output logic [7:0] d, output logic oe);
    @(posedge ref_clk);
    addrR <= b;
    @(posedge ref_clk);
    rdR <= 1'b1;
    repeat (6) @(posedge ref_clk);
    d = dataOut;
    oe = dataOe;
    rdR <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : host_read
  task automatic periph(input logic on, input logic [7:0] d);
    drvOn <= on;
    drvByte <= d;
  endtask : periph
endmodule : ppt_host_model

// ### tb/parallel_port_timing_address_status_tb.sv
module parallel_port_timing_address_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ppt_pkg::*;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, dataOe, rdStrobe, wrStrobe;
  logic busy, err, oe;
  logic [7:0] paddr, dataOut, hb;
  logic [31:0] pwdata, prdata, rv, m;
  logic [14:0] addrOut, addrOe, seenAddr, seenOe;
  ppt_pins_t pinIn;
  int errors, tests_run, nb, ns, s, h;
  logic [3:0] tm [3] = '{4'h0, 4'hf, 4'h1};
  logic [1:0] tw [3] = '{2'h3, 2'h3, 2'h0};
  ppt_port_cfg DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinIn(pinIn), .dataOut(dataOut), .dataOe(dataOe),
    .rdStrobe(rdStrobe), .wrStrobe(wrStrobe), .addrOut(addrOut), .addrOe(addrOe), .busy(busy));
  ppt_host_model HOST (.ref_clk(ref_clk), .dataOut(dataOut), .dataOe(dataOe), .pins(pinIn));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic final_report;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // Setup then access; waits on pready since wait states are the slave's call
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(a, 1'b0, 32'h0000_0000);
    chk(rv, exp, what);
  endtask : rd
  // Fixed window is longer than the slowest transfer
  task automatic xfer(input logic [7:0] a, input logic isRd);
    apb(a, 1'b1, 32'h0000_005a);
    nb = 0;
    ns = 0;
    repeat (40) begin
      @(posedge ref_clk);
      if (busy === 1'b1) begin
        if (nb == 0) begin
          seenAddr = addrOut;
          seenOe = addrOe;
        end
        nb++;
      end
      if ((isRd ? rdStrobe : wrStrobe) === 1'b1) ns++;
    end
  endtask : xfer
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(OFF_MODE, 32'h0000_0000, "mode reset");
    rd(OFF_ADDR, 32'h0000_0000, "addr reset");
    rd(OFF_PEN, 32'h0000_0000, "pen reset");
    rd(OFF_STAT, 32'h0000_008f, "stat reset");
    apb(8'h40, 1'b0, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001, "unmapped error");
    apb(OFF_ADDR, 1'b1, 32'hffff_ffff);
    rd(OFF_ADDR, 32'h0000_47ff, "addr width");
    apb(OFF_PEN, 1'b1, 32'hffff_ffff);
    rd(OFF_PEN, 32'h0000_47ff, "pen width");
    apb(OFF_MODE, 1'b1, 32'hffff_ffff);
    rd(OFF_MODE, 32'h0000_7bff, "mode width");
  endtask : t_reset
  task automatic t_timing;
    apb(OFF_CTRL, 1'b1, 32'h0000_8003);
    HOST.periph(1'b1, 8'ha5);
    for (int i = 0; i < 3; i++) begin
      s = (tm[i] == 0) ? 1 : tw[i] + 1;
      for (int md = 2; md < 4; md++) begin
        apb(OFF_MODE, 1'b1, (md << 8) | (tw[i] << 6) | (tm[i] << 2) | tw[i]);
        xfer(OFF_WDATA, 1'b0);
        h = (tm[i] == 0) ? 1 : tw[i] + 1;
        chk(ns, tm[i] + 1, "write strobe");
        chk(nb, s + tm[i] + 1 + h, "write busy");
        // Combined mode puts the read strobe on the enable line
        xfer(OFF_RDATA, md == 2);
        h = (tm[i] == 0) ? 0 : tw[i];
        chk(ns, tm[i] + 1, "read strobe");
        chk(nb, s + tm[i] + 1 + h, "read busy");
        rd(OFF_RDATA, 32'h0000_00a5, "read byte");
      end
    end
    HOST.periph(1'b0, 8'h00);
  endtask : t_timing
  task automatic t_addr;
    apb(OFF_CTRL, 1'b1, 32'h0000_808b);
    apb(OFF_ADDR, 1'b1, 32'h0000_4001);
    apb(OFF_MODE, 1'b1, 32'h0000_0a00);
    xfer(OFF_WDATA, 1'b0);
    chk(seenAddr, 15'h4001, "addr pins");
    chk(seenOe, 15'h47ff, "addr enables");
    rd(OFF_ADDR, 32'h0000_4005, "addr step up");
    apb(OFF_MODE, 1'b1, 32'h0000_1200);
    xfer(OFF_WDATA, 1'b0);
    rd(OFF_ADDR, 32'h0000_4001, "addr step down");
    apb(OFF_CTRL, 1'b1, 32'h0000_8003);
    apb(OFF_PEN, 1'b1, 32'h0000_0004);
    xfer(OFF_WDATA, 1'b0);
    chk(seenOe, 15'h0004, "pin as port");
    apb(OFF_CTRL, 1'b1, 32'h0000_8823);
    xfer(OFF_WDATA, 1'b0);
    chk(seenAddr, 15'h07ff, "latch strobes");
  endtask : t_addr
  task automatic t_slave;
    apb(OFF_CTRL, 1'b1, 32'h0000_8000);
    apb(OFF_MODE, 1'b1, 32'h0000_1800);
    HOST.host_write(2'b10, 8'h21);
    HOST.host_write(2'b10, 8'h22);
    rd(OFF_STAT, 32'h0000_038f, "legacy advance");
    rd(OFF_IBUF, 32'h0000_0021, "legacy buf0");
    rd(OFF_IBUF + 8'h04, 32'h0000_0022, "legacy buf1");
    apb(OFF_MODE, 1'b1, 32'h0000_0100);
    m = 0;
    for (int i = 0; i < 4; i++) begin
      HOST.host_write(i[1:0], 8'h10 + i[7:0]);
      m = m | (32'h100 << i);
      rd(OFF_STAT, 32'h8f | m | ((i == 3) ? 32'h8000 : 0), "input fill");
    end
    HOST.host_write(2'b00, 8'h77);
    rd(OFF_STAT, 32'h0000_cf8f, "overflow");
    rd(OFF_IBUF, 32'h0000_0010, "buf0 kept");
    rd(OFF_STAT, 32'h0000_4e8f, "read clears");
    apb(OFF_STAT, 1'b1, 32'h0000_0000);
    rd(OFF_STAT, 32'h0000_0e8f, "flag clear");
    HOST.host_read(2'b10, hb, oe);
    rd(OFF_STAT, 32'h0000_0ecf, "underflow");
    apb(OFF_OUTPUT_UNDERFLOW_FLAG + 8'h04, 1'b1, 32'h0000_003c);
    rd(OFF_STAT, 32'h0000_0e4d, "output loaded");
    HOST.host_read(2'b01, hb, oe);
    chk({23'h0, oe, hb}, 32'h0000_013c, "host byte");
  endtask : t_slave
  // ----------------------------------------
  // Run
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    errors = 0;
    tests_run = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_timing();
    t_addr();
    t_slave();
    final_report();
  end
endmodule : parallel_port_timing_address_status_tb
